/* verilog/mfc_cfg.svh */
// Purpose: constants of the motor flag and fault block
// Assumes: 32-bit register port, one word per register
// Notes: offsets are byte addresses
// Function
// - Low sixteen bits select flag set address
// - Bit16 clear: output is amplifier enable
// - Bit16 set: output not amplifier enable
// - Direction bit only when output mode bit16
// - Bit17 clear: limit low permits motion
// - Positive limit blocks negative, and reverse
// - Bit17 set: hardware limits ignored
// - Software limits active when nonzero only
// - Bit18 selects direct pins or ring
// - Bit20 set disables amplifier fault function
// - Fault or fatal following error triggers response
// - Bits22..21 choose kill scope
// - Always halt program of motor's system
// - Bit23 picks fault input polarity
// - Limit inputs readable as general inputs
`ifndef MFC_CFG_SVH
`define MFC_CFG_SVH
`define MFC_OFS_FLAG_CFG 8'h00
`define MFC_OFS_OUT_MODE 8'h04
`define MFC_OFS_FFE_LIM 8'h08
`define MFC_OFS_POS_SWL 8'h0c
`define MFC_OFS_NEG_SWL 8'h10
`define MFC_OFS_IRQ_STAT 8'h14
`define MFC_OFS_IRQ_MASK 8'h18
`define MFC_OFS_CTRL 8'h1c
`define MFC_OFS_STATUS 8'h20
`define MFC_BIT_NO_AMP_EN 16
`define MFC_BIT_NO_HW_LIM 17
`define MFC_BIT_RING 18
`define MFC_BIT_NO_FAULT 20
`define MFC_BIT_SCOPE_CS 21
`define MFC_BIT_SCOPE_SELF 22
`define MFC_BIT_FAULT_HI 23
`define MFC_BIT_DIR_MODE 16
`define MFC_CTRL_ENA 0
`define MFC_CTRL_KILL 1
`define MFC_CTRL_GPO 2
`define MFC_IRQ_W 4
`define MFC_FLAG_CFG_RST 24'h000000
`define MFC_OUT_MODE_RST 24'h000000
`define MFC_LIM_RST 24'h000000
`define MFC_IRQ_RST 4'h0
`define MFC_SYNC_STAGES 2
`endif

/* verilog/mfc_pkg.sv */
// Purpose: types of the motor flag and fault block
// Assumes: nothing
// Notes: interrupt bit order follows mfc_irq_t
`default_nettype none
package mfc_pkg;
	typedef enum logic [1:0] {
		MFC_KILLED,
		MFC_ENABLED
	} mfc_state_t;
	typedef struct packed {
		logic neg_hit;
		logic pos_hit;
		logic ffe;
		logic fault;
	} mfc_irq_t;
endpackage
`default_nettype wire

/* verilog/mfc_flag_if.sv */
// Purpose: synchronised flags from front end to core
// Assumes: one clock
// Notes: levels only
`timescale 1ns/1ns
`default_nettype none
interface mfc_flag_if;
	logic pos_lim;
	logic neg_lim;
	logic fault;
	logic en_pol;
	modport src (output pos_lim, output neg_lim, output fault, output en_pol);
	modport dst (input pos_lim, input neg_lim, input fault, input en_pol);
endinterface
`default_nettype wire

/* verilog/mfc_flag_front.sv */
// Purpose: synchronise flag pins and pick the flag source
// Assumes: pins are asynchronous to clk_i
// Notes: selection made after the second flop only
`timescale 1ns/1ns
`default_nettype none
module mfc_flag_front #(
	parameter int W = 3
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ring_sel_i,
	input wire logic [W-1:0] direct_i,
	input wire logic [W-1:0] ring_i,
	input wire logic jumper_i,
	mfc_flag_if.src flags
);
	logic [2*W:0] s1_ff;
	logic [2*W:0] s2_ff;
	logic [2*W:0] nxt_s1;
	logic [2*W:0] nxt_s2;
	logic [W-1:0] pick;

	always_comb begin
		nxt_s1 = {jumper_i, ring_i, direct_i};
		nxt_s2 = s1_ff;
		pick = ring_sel_i ? s2_ff[2*W-1:W] : s2_ff[W-1:0];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
		end
	end

	assign flags.pos_lim = pick[0];
	assign flags.neg_lim = pick[1];
	assign flags.fault = pick[2];
	assign flags.en_pol = s2_ff[2*W];
endmodule
`default_nettype wire

/* verilog/mfc_motor_flags.sv */
// Purpose: per-motor flag config, limits and fault kill
// Assumes: servo loop and ring logic share clk_i
// Notes: kill scope outputs are one-cycle pulses
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "mfc_cfg.svh"
module mfc_motor_flags
	import mfc_pkg::*;
#(
	parameter int PW = 24
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic positive_limit_input_i,
	input wire logic negative_limit_input_i,
	input wire logic amp_fault_input_i,
	input wire logic ring_pos_limit_i,
	input wire logic ring_neg_limit_i,
	input wire logic ring_amp_fault_i,
	input wire logic enable_polarity_jumper_i,
	input wire logic cmd_pos_motion_i,
	input wire logic cmd_neg_motion_i,
	input wire logic cmd_dir_i,
	input wire logic signed [PW-1:0] following_error_i,
	input wire logic signed [PW-1:0] position_i,
	input wire logic kill_all_in_i,
	input wire logic kill_cs_in_i,
	output logic [15:0] flag_set_addr_o,
	output logic amp_enable_dir_output_o,
	output logic servo_output_en_o,
	output logic pos_motion_allow_o,
	output logic neg_motion_allow_o,
	output logic soft_limit_active_o,
	output logic kill_all_o,
	output logic kill_cs_o,
	output logic kill_self_o,
	output logic program_halt_o,
	output logic irq_o
);
	mfc_flag_if flg ();

	logic [23:0] flag_cfg_ff;
	logic [23:0] nxt_flag_cfg;
	logic [23:0] out_mode_ff;
	logic [23:0] nxt_out_mode;
	logic [PW-1:0] ffe_lim_ff;
	logic [PW-1:0] nxt_ffe_lim;
	logic signed [PW-1:0] pos_swl_ff;
	logic signed [PW-1:0] nxt_pos_swl;
	logic signed [PW-1:0] neg_swl_ff;
	logic signed [PW-1:0] nxt_neg_swl;
	mfc_irq_t irq_stat_ff;
	mfc_irq_t nxt_irq_stat;
	mfc_irq_t irq_mask_ff;
	mfc_irq_t nxt_irq_mask;
	mfc_irq_t irq_set;
	logic gpo_ff;
	logic nxt_gpo;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	mfc_state_t state_ff;
	mfc_state_t nxt_state;
	logic amp_out_ff;
	logic nxt_amp_out;
	logic pos_allow_ff;
	logic nxt_pos_allow;
	logic neg_allow_ff;
	logic nxt_neg_allow;
	logic kill_all_ff;
	logic nxt_kill_all;
	logic kill_cs_ff;
	logic nxt_kill_cs;
	logic kill_self_ff;
	logic nxt_kill_self;
	logic halt_ff;
	logic nxt_halt;

	logic wr_ctrl;
	logic ena_req;
	logic kill_req;
	logic enabled;
	logic hw_lim_en;
	logic fault_en;
	logic fault_act;
	logic fault_evt;
	logic [PW-1:0] fe_abs;
	logic ffe_evt;
	logic any_evt;
	logic pos_swl_on;
	logic neg_swl_on;
	logic pos_block;
	logic neg_block;

	mfc_flag_front #(
		.W(3)
	) u_front (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ring_sel_i(flag_cfg_ff[`MFC_BIT_RING]),
		.direct_i({amp_fault_input_i, negative_limit_input_i, positive_limit_input_i}),
		.ring_i({ring_amp_fault_i, ring_neg_limit_i, ring_pos_limit_i}),
		.jumper_i(enable_polarity_jumper_i),
		.flags(flg.src)
	);

	// Decode of derived controls
	always_comb begin
		enabled = (state_ff == MFC_ENABLED);
		hw_lim_en = !flag_cfg_ff[`MFC_BIT_NO_HW_LIM];
		fault_en = !flag_cfg_ff[`MFC_BIT_NO_FAULT];
		// Low-true by default; pin idles high
		fault_act = fault_en && (flag_cfg_ff[`MFC_BIT_FAULT_HI] ? flg.fault : !flg.fault);
		fe_abs = following_error_i[PW-1] ? -following_error_i : following_error_i;
		// Zero limit means the check is off
		ffe_evt = enabled && (ffe_lim_ff != '0) && (fe_abs > ffe_lim_ff);
		fault_evt = enabled && fault_act;
		any_evt = fault_evt || ffe_evt;
		pos_swl_on = (pos_swl_ff != '0);
		neg_swl_on = (neg_swl_ff != '0);
	end

	// Motion gating
	always_comb begin
		// Positive switch stops negative travel
		neg_block = hw_lim_en && flg.pos_lim;
		pos_block = hw_lim_en && flg.neg_lim;
		nxt_pos_allow = cmd_pos_motion_i && enabled && !pos_block;
		nxt_neg_allow = cmd_neg_motion_i && enabled && !neg_block;
		if (pos_swl_on && (position_i >= pos_swl_ff)) begin
			nxt_pos_allow = 1'b0;
		end
		if (neg_swl_on && (position_i <= neg_swl_ff)) begin
			nxt_neg_allow = 1'b0;
		end
		irq_set.fault = fault_evt;
		irq_set.ffe = ffe_evt;
		irq_set.pos_hit = cmd_pos_motion_i && enabled && pos_block;
		irq_set.neg_hit = cmd_neg_motion_i && enabled && neg_block;
	end

	// Enable state and fault response
	always_comb begin
		nxt_state = state_ff;
		nxt_kill_all = 1'b0;
		nxt_kill_cs = 1'b0;
		nxt_kill_self = 1'b0;
		nxt_halt = 1'b0;
		case (state_ff)
			MFC_KILLED: begin
				// No enable into a standing fault
				if (ena_req && !kill_req && !fault_act) begin
					nxt_state = MFC_ENABLED;
				end
			end
			MFC_ENABLED: begin
				if (any_evt) begin
					nxt_state = MFC_KILLED;
					nxt_halt = 1'b1;
					if (flag_cfg_ff[`MFC_BIT_SCOPE_SELF]) begin
						nxt_kill_self = 1'b1;
					end else if (flag_cfg_ff[`MFC_BIT_SCOPE_CS]) begin
						nxt_kill_cs = 1'b1;
					end else begin
						nxt_kill_all = 1'b1;
					end
				end else if (kill_req || kill_all_in_i || kill_cs_in_i) begin
					nxt_state = MFC_KILLED;
				end
			end
			default: begin
				nxt_state = MFC_KILLED;
			end
		endcase
	end

	// Enable/direction line
	always_comb begin
		if (!flag_cfg_ff[`MFC_BIT_NO_AMP_EN]) begin
			// Jumper sets the voltage sense
			nxt_amp_out = (nxt_state == MFC_ENABLED) ^ flg.en_pol;
		end else if (out_mode_ff[`MFC_BIT_DIR_MODE]) begin
			nxt_amp_out = cmd_dir_i;
		end else begin
			nxt_amp_out = gpo_ff;
		end
	end

	// Register port
	always_comb begin
		wr_ctrl = reg_wr_i && (reg_addr_i == `MFC_OFS_CTRL);
		ena_req = wr_ctrl && reg_wdata_i[`MFC_CTRL_ENA];
		kill_req = wr_ctrl && reg_wdata_i[`MFC_CTRL_KILL];
		nxt_flag_cfg = flag_cfg_ff;
		nxt_out_mode = out_mode_ff;
		nxt_ffe_lim = ffe_lim_ff;
		nxt_pos_swl = pos_swl_ff;
		nxt_neg_swl = neg_swl_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_gpo = gpo_ff;
		nxt_irq_stat = irq_stat_ff;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`MFC_OFS_FLAG_CFG: nxt_flag_cfg = reg_wdata_i[23:0];
				`MFC_OFS_OUT_MODE: nxt_out_mode = reg_wdata_i[23:0];
				`MFC_OFS_FFE_LIM: nxt_ffe_lim = reg_wdata_i[PW-1:0];
				`MFC_OFS_POS_SWL: nxt_pos_swl = reg_wdata_i[PW-1:0];
				`MFC_OFS_NEG_SWL: nxt_neg_swl = reg_wdata_i[PW-1:0];
				`MFC_OFS_IRQ_MASK: nxt_irq_mask = reg_wdata_i[`MFC_IRQ_W-1:0];
				`MFC_OFS_IRQ_STAT: nxt_irq_stat = irq_stat_ff & ~reg_wdata_i[`MFC_IRQ_W-1:0];
				`MFC_OFS_CTRL: nxt_gpo = reg_wdata_i[`MFC_CTRL_GPO];
				default: begin
				end
			endcase
		end
		// Set applied last so a new event beats its clear
		nxt_irq_stat = nxt_irq_stat | irq_set;
		nxt_rdata = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`MFC_OFS_FLAG_CFG: nxt_rdata = {8'h00, flag_cfg_ff};
				`MFC_OFS_OUT_MODE: nxt_rdata = {8'h00, out_mode_ff};
				`MFC_OFS_FFE_LIM: nxt_rdata[PW-1:0] = ffe_lim_ff;
				`MFC_OFS_POS_SWL: nxt_rdata[PW-1:0] = pos_swl_ff;
				`MFC_OFS_NEG_SWL: nxt_rdata[PW-1:0] = neg_swl_ff;
				`MFC_OFS_IRQ_STAT: nxt_rdata[`MFC_IRQ_W-1:0] = irq_stat_ff;
				`MFC_OFS_IRQ_MASK: nxt_rdata[`MFC_IRQ_W-1:0] = irq_mask_ff;
				`MFC_OFS_CTRL: nxt_rdata[3:0] = {enabled, gpo_ff, 2'b00};
				// Limit pins, or ring limits when bit18 set, readable whatever their use
				`MFC_OFS_STATUS: nxt_rdata[5:0] = {pos_swl_on || neg_swl_on, enabled, fault_act,
					flg.fault, flg.neg_lim, flg.pos_lim};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_cfg_ff <= `MFC_FLAG_CFG_RST;
			out_mode_ff <= `MFC_OUT_MODE_RST;
			ffe_lim_ff <= `MFC_LIM_RST;
			pos_swl_ff <= `MFC_LIM_RST;
			neg_swl_ff <= `MFC_LIM_RST;
			irq_stat_ff <= `MFC_IRQ_RST;
			irq_mask_ff <= `MFC_IRQ_RST;
			gpo_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			flag_cfg_ff <= nxt_flag_cfg;
			out_mode_ff <= nxt_out_mode;
			ffe_lim_ff <= nxt_ffe_lim;
			pos_swl_ff <= nxt_pos_swl;
			neg_swl_ff <= nxt_neg_swl;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
			gpo_ff <= nxt_gpo;
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= MFC_KILLED;
			amp_out_ff <= 1'b0;
			pos_allow_ff <= 1'b0;
			neg_allow_ff <= 1'b0;
			kill_all_ff <= 1'b0;
			kill_cs_ff <= 1'b0;
			kill_self_ff <= 1'b0;
			halt_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			amp_out_ff <= nxt_amp_out;
			pos_allow_ff <= nxt_pos_allow;
			neg_allow_ff <= nxt_neg_allow;
			kill_all_ff <= nxt_kill_all;
			kill_cs_ff <= nxt_kill_cs;
			kill_self_ff <= nxt_kill_self;
			halt_ff <= nxt_halt;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign flag_set_addr_o = flag_cfg_ff[15:0];
	assign amp_enable_dir_output_o = amp_out_ff;
	assign servo_output_en_o = enabled;
	assign pos_motion_allow_o = pos_allow_ff;
	assign neg_motion_allow_o = neg_allow_ff;
	assign soft_limit_active_o = pos_swl_on || neg_swl_on;
	assign kill_all_o = kill_all_ff;
	assign kill_cs_o = kill_cs_ff;
	assign kill_self_o = kill_self_ff;
	assign program_halt_o = halt_ff;
	assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule
`default_nettype wire

/* testbench/mfc_motor_flags_properties.sv */
// Purpose: port checks of the motor flag block
// Assumes: one clock, async active-low reset
// Notes: shadows config writes to judge kill scope
`timescale 1ns/1ns
`default_nettype none
module mfc_motor_flags_properties (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic cmd_pos_motion_i,
	input wire logic pos_motion_allow_o,
	input wire logic servo_output_en_o,
	input wire logic soft_limit_active_o,
	input wire logic kill_all_o,
	input wire logic kill_cs_o,
	input wire logic kill_self_o,
	input wire logic program_halt_o
);
	logic [23:0] cfg_ff, nxt_cfg;
	logic [1:0] swl_ff, nxt_swl;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_swl = swl_ff;
		if (reg_wr_i && reg_addr_i == 8'h00) nxt_cfg = reg_wdata_i[23:0];
		if (reg_wr_i && reg_addr_i == 8'h0c) nxt_swl[0] = |reg_wdata_i[23:0];
		if (reg_wr_i && reg_addr_i == 8'h10) nxt_swl[1] = |reg_wdata_i[23:0];
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_ff <= 24'h000000;
			swl_ff <= 2'h0;
		end else begin
			cfg_ff <= nxt_cfg;
			swl_ff <= nxt_swl;
		end
	end
	halt_one_kill_a: assert property (program_halt_o |-> $onehot({kill_all_o, kill_cs_o, kill_self_o}))
		else $error("halt without one kill");
	kill_has_halt_a: assert property (kill_all_o || kill_cs_o || kill_self_o |-> program_halt_o)
		else $error("kill without halt");
	halt_drops_servo_a: assert property (program_halt_o |-> !servo_output_en_o)
		else $error("servo kept on kill");
	halt_after_en_a: assert property (program_halt_o |-> $past(servo_output_en_o))
		else $error("halt while killed");
	scope_self_a: assert property (program_halt_o && $past(cfg_ff[22]) |-> kill_self_o)
		else $error("scope self wrong");
	scope_cs_a: assert property (program_halt_o && $past(cfg_ff[22:21]) == 2'b01 |-> kill_cs_o)
		else $error("scope cs wrong");
	scope_all_a: assert property (program_halt_o && $past(cfg_ff[22:21]) == 2'b00 |-> kill_all_o)
		else $error("scope all wrong");
	no_cmd_move_a: assert property (!cmd_pos_motion_i |=> !pos_motion_allow_o)
		else $error("motion without command");
	soft_active_a: assert property ($past(swl_ff) == swl_ff |-> soft_limit_active_o == (swl_ff != 2'h0))
		else $error("soft limit flag wrong");
	cover property (kill_self_o);
	cover property (kill_cs_o);
	cover property (soft_limit_active_o);
endmodule
`default_nettype wire

/* testbench/mfc_amp_model.sv */
// Purpose: amplifier fault line and limit switches
// Assumes: requests come from the bench
// Notes: no fault line delay is modelled
`timescale 1ns/1ns
`default_nettype none
module mfc_amp_model (
	input wire logic fault_req_i,
	input wire logic [1:0] lim_req_i,
	output logic fault_pin_o,
	output logic pos_lim_o,
	output logic neg_lim_o
);
	// Pulled-up line, low means fault
	assign fault_pin_o = !fault_req_i;
	// Healthy switch holds the line low
	assign pos_lim_o = lim_req_i[0];
	assign neg_lim_o = lim_req_i[1];
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench of the motor flag block
// Assumes: jumper low outside its own check
// Notes: read data scored from a queue at falling edges
`timescale 1ns/1ns
`default_nettype none
bind mfc_motor_flags mfc_motor_flags_properties i_prop (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .cmd_pos_motion_i, .pos_motion_allow_o, .servo_output_en_o, .soft_limit_active_o,
	.kill_all_o, .kill_cs_o, .kill_self_o, .program_halt_o);
module testbench;
	logic clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, flt_req = 1'b0, rd_q = 1'b0;
	logic enable_polarity_jumper_i = 1'b0, cmd_pos_motion_i = 1'b0, cmd_neg_motion_i = 1'b0, cmd_dir_i = 1'b0;
	logic ring_pos_limit_i = 1'b0, kill_all_in_i = 1'b0, kill_cs_in_i = 1'b0;
	logic [1:0] lim_req = 2'h0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rs = 32'h0000646e;
	logic signed [23:0] following_error_i = 24'h0, position_i = 24'h0;
	logic [15:0] flag_set_addr_o;
	logic amp_enable_dir_output_o, servo_output_en_o, pos_motion_allow_o, neg_motion_allow_o;
	logic soft_limit_active_o, kill_all_o, kill_cs_o, kill_self_o, program_halt_o, irq_o;
	wire logic positive_limit_input_i, negative_limit_input_i, amp_fault_input_i;
	logic [31:0] q[$];
	int fails = 0, compares = 0, cyc = 0;
	mfc_motor_flags #(.PW(24)) i_dut (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .positive_limit_input_i, .negative_limit_input_i, .amp_fault_input_i,
		.ring_pos_limit_i, .ring_neg_limit_i(1'b0), .ring_amp_fault_i(1'b1), .enable_polarity_jumper_i,
		.cmd_pos_motion_i, .cmd_neg_motion_i, .cmd_dir_i, .following_error_i, .position_i, .kill_all_in_i,
		.kill_cs_in_i, .flag_set_addr_o, .amp_enable_dir_output_o, .servo_output_en_o, .pos_motion_allow_o,
		.neg_motion_allow_o, .soft_limit_active_o, .kill_all_o, .kill_cs_o, .kill_self_o, .program_halt_o,
		.irq_o);
	mfc_amp_model i_amp (.fault_req_i(flt_req), .lim_req_i(lim_req), .fault_pin_o(amp_fault_input_i),
		.pos_lim_o(positive_limit_input_i), .neg_lim_o(negative_limit_input_i));
	always #2 clk_i = !clk_i;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		q.push_back(e);
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask
	task automatic nb(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	// Expected kill pulses given as self, cs, all
	task automatic flt(input logic [2:0] e);
		logic h;
		h = 1'b0;
		repeat (8) begin
			@(negedge clk_i);
			if (program_halt_o === 1'b1 && !h) begin
				h = 1'b1;
				chk({kill_self_o, kill_cs_o, kill_all_o}, e);
			end
		end
		chk(h, |e);
	endtask
	always @(posedge clk_i) rd_q <= reg_rd_i;
	always @(negedge clk_i) begin
		if (rd_q) begin
			chk(reg_rdata_o, q.pop_front());
		end
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			end_of_test;
		end
	end
	initial begin
		int i;
		logic [31:0] d;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(8'h00, 32'h0);
		wr(8'h44, 32'hffffffff);
		rd(8'h44, 32'h0);
		for (i = 0; i < 4; i++) begin
			d = rnd() & 32'h0000ffff;
			wr(8'h00, d);
			nb(1);
			chk(flag_set_addr_o, d);
			rd(8'h00, d);
		end
		wr(8'h00, 32'h0);
		nb(1);
		chk(amp_enable_dir_output_o, 1'b0);
		wr(8'h1c, 32'h1);
		nb(3);
		chk({servo_output_en_o, amp_enable_dir_output_o}, 2'b11);
		@(posedge clk_i);
		enable_polarity_jumper_i <= 1'b1;
		nb(4);
		chk(amp_enable_dir_output_o, 1'b0);
		@(posedge clk_i);
		enable_polarity_jumper_i <= 1'b0;
		{cmd_neg_motion_i, cmd_pos_motion_i} <= 2'b11;
		for (i = 0; i < 4; i++) begin
			if (i == 2) wr(8'h00, 32'h00020000);
			@(posedge clk_i);
			lim_req <= i[0] ? 2'b10 : 2'b01;
			nb(4);
			chk({pos_motion_allow_o, neg_motion_allow_o}, i > 1 ? 2'b11 : i[0] ? 2'b01 : 2'b10);
		end
		@(posedge clk_i);
		lim_req <= 2'b11;
		nb(3);
		rd(8'h20, 32'h17);
		wr(8'h0c, 32'h64);
		@(posedge clk_i);
		position_i <= 24'h0000c8;
		nb(3);
		chk({soft_limit_active_o, pos_motion_allow_o}, 2'b10);
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h00040000);
		@(posedge clk_i);
		ring_pos_limit_i <= 1'b1;
		lim_req <= 2'b10;
		nb(4);
		chk({soft_limit_active_o, pos_motion_allow_o, neg_motion_allow_o}, 3'b010);
		rd(8'h20, 32'h15);
		@(posedge clk_i);
		ring_pos_limit_i <= 1'b0;
		lim_req <= 2'b00;
		{cmd_neg_motion_i, cmd_pos_motion_i} <= 2'b00;
		wr(8'h00, 32'h00010000);
		wr(8'h1c, 32'h4);
		nb(2);
		chk(amp_enable_dir_output_o, 1'b1);
		wr(8'h04, 32'h00010000);
		for (i = 0; i < 4; i++) begin
			d = rnd();
			@(posedge clk_i);
			cmd_dir_i <= d[0];
			nb(2);
			chk(amp_enable_dir_output_o, d[0]);
		end
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0);
		for (i = 0; i < 2; i++) begin
			wr(8'h1c, 32'h1);
			@(posedge clk_i);
			{kill_all_in_i, kill_cs_in_i} <= 2'b01 << i;
			nb(3);
			chk({servo_output_en_o, amp_enable_dir_output_o, program_halt_o}, 3'b000);
			@(posedge clk_i);
			{kill_all_in_i, kill_cs_in_i} <= 2'b00;
		end
		wr(8'h14, 32'hf);
		wr(8'h18, 32'h1);
		for (i = 0; i < 4; i++) begin
			// Bit23 low suits the pulled-up idle line
			wr(8'h00, i << 21);
			wr(8'h1c, 32'h1);
			@(posedge clk_i);
			flt_req <= 1'b1;
			flt(i[1] ? 3'b100 : i[0] ? 3'b010 : 3'b001);
			chk({irq_o, servo_output_en_o}, 2'b10);
			rd(8'h14, 32'h1);
			@(posedge clk_i);
			flt_req <= 1'b0;
			wr(8'h14, 32'h1);
			nb(3);
			chk(irq_o, 1'b0);
		end
		@(posedge clk_i);
		flt_req <= 1'b1;
		wr(8'h00, 32'h00800000);
		wr(8'h1c, 32'h1);
		@(posedge clk_i);
		flt_req <= 1'b0;
		flt(3'b001);
		@(posedge clk_i);
		flt_req <= 1'b1;
		wr(8'h00, 32'h00100000);
		wr(8'h1c, 32'h1);
		flt(3'b000);
		wr(8'h08, 32'h32);
		@(posedge clk_i);
		following_error_i <= 24'h000064;
		flt(3'b001);
		end_of_test;
	end
endmodule
`default_nettype wire
